// file: hdl/mq_pkg.sv
package mq_pkg;

    // Queue array geometry
    localparam int NUM_QUEUES     = 128;
    localparam int QADDR_W        = 7;
    localparam int ADDR_W         = 8;
    localparam int DATA_W         = 36;
    localparam int QUEUE_DEPTH    = 4;
    localparam int PTR_W          = 2;
    localparam int CNT_W          = 3;
    localparam int AF_OFFSET      = 1;

    // Address bus fields
    localparam int DEVSEL_BIT     = 7;
    localparam int STAT_WORD_W    = 4;
    localparam int AF_BUS_W       = 8;

    // Queue change timing in write-clock cycles
    localparam int CHG_CYCLES     = 4;
    localparam int CHG_OLD_CYCLES = 3;
    localparam logic [1:0] CHG_LOAD = 2'(CHG_OLD_CYCLES - 2);

    // Cycles of internal setup before programming is done
    localparam int PROG_CYCLES    = 8;
    localparam int PROG_CNT_W     = 4;

    // Register map (byte addresses)
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0c;

    // Field positions
    localparam int CTRL_WDIS_BIT   = 0;
    localparam int ST_PKT_BIT      = 0;
    localparam int ST_FT_BIT       = 1;
    localparam int ST_DONE_BIT     = 2;
    localparam int ST_BUSY_BIT     = 3;
    localparam int ST_WQ_LSB       = 8;
    localparam int ST_RQ_LSB       = 16;
    localparam int IRQ_REFUSED_BIT = 0;
    localparam int IRQ_CHANGED_BIT = 1;
    localparam int IRQ_W           = 2;

    // Reset values
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
    localparam logic             CTRL_WDIS_RST = 1'b0;

endpackage

// file: hdl/queue_store.sv
`timescale 1ns/100ps
`default_nettype none

module queue_store
    import mq_pkg::*;
(
    // Clock and reset
    input  wire logic                                sys_clk_i,
    input  wire logic                                rst_i,
    // Write side
    input  wire logic                                wr_en_i,
    input  wire logic [QADDR_W-1:0]                  wr_q_i,
    input  wire logic [DATA_W-1:0]                   wr_data_i,
    // Read side
    input  wire logic                                rd_en_i,
    input  wire logic [QADDR_W-1:0]                  rd_q_i,
    output logic      [DATA_W-1:0]                   rd_data_o,
    // Occupancy of every queue
    output logic      [NUM_QUEUES-1:0][CNT_W-1:0]    count_o
);

    typedef struct packed {
        logic [NUM_QUEUES-1:0][QUEUE_DEPTH-1:0][DATA_W-1:0] mem;
        logic [NUM_QUEUES-1:0][PTR_W-1:0]                   wp;
        logic [NUM_QUEUES-1:0][PTR_W-1:0]                   rp;
        logic [NUM_QUEUES-1:0][CNT_W-1:0]                   cnt;
        logic [DATA_W-1:0]                                  rdata;
    } store_s;

    store_s s_r;
    store_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (wr_en_i) begin
            s_nxt.mem[wr_q_i][s_r.wp[wr_q_i]] = wr_data_i;
            s_nxt.wp[wr_q_i] = s_r.wp[wr_q_i] + 1'b1;
        end
        if (rd_en_i) begin
            s_nxt.rdata = s_r.mem[rd_q_i][s_r.rp[rd_q_i]];
            s_nxt.rp[rd_q_i] = s_r.rp[rd_q_i] + 1'b1;
        end
        // Same-queue write and read leave the count unchanged
        if (wr_en_i && !(rd_en_i && rd_q_i == wr_q_i)) begin
            s_nxt.cnt[wr_q_i] = s_r.cnt[wr_q_i] + 1'b1;
        end
        if (rd_en_i && !(wr_en_i && rd_q_i == wr_q_i)) begin
            s_nxt.cnt[rd_q_i] = s_r.cnt[rd_q_i] - 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rd_data_o = s_r.rdata;
    assign count_o   = s_r.cnt;

endmodule

`default_nettype wire

// file: hdl/multi_queue_write_port_select.sv
`timescale 1ns/100ps
`default_nettype none

module multi_queue_write_port_select
    import mq_pkg::*;
(
    // Clock and reset
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_i,
    // Configuration pins
    input  wire logic                 packet_mode_select_i,
    input  wire logic                 fall_through_select_i,
    input  wire logic                 device_id_i,
    // Write port
    input  wire logic [DATA_W-1:0]    write_data_i,
    input  wire logic                 write_en_n_i,
    input  wire logic [ADDR_W-1:0]    write_addr_bus_i,
    input  wire logic                 write_addr_strobe_i,
    input  wire logic                 flag_status_strobe_i,
    output logic                      write_flag_n_o,
    output logic      [AF_BUS_W-1:0]  almost_full_n_o,
    // Read port
    input  wire logic [ADDR_W-1:0]    read_addr_bus_i,
    input  wire logic                 read_addr_strobe_i,
    input  wire logic                 read_en_n_i,
    output logic      [DATA_W-1:0]    read_data_o,
    output logic                      read_flag_n_o,
    // Programming status
    output logic                      program_done_n_o,
    // APB slave
    input  wire logic [7:0]           paddr_i,
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [31:0]          pwdata_i,
    output logic      [31:0]          prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    output logic                      irq_o
);

    typedef struct packed {
        logic                  mode_pkt;
        logic                  mode_ft;
        logic                  mode_seen;
        logic [PROG_CNT_W-1:0] prog_cnt;
        logic                  prog_done_n;
        logic [QADDR_W-1:0]    wq;
        logic [QADDR_W-1:0]    pend_q;
        logic [1:0]            chg_cnt;
        logic                  chg_busy;
        logic [QADDR_W-1:0]    rq;
        logic                  wflag_n;
        logic                  rflag_n;
        logic [STAT_WORD_W-1:0] af_word;
        logic [AF_BUS_W-1:0]   af_n;
        logic                  wdis;
        logic [IRQ_W-1:0]      irq_stat;
        logic [IRQ_W-1:0]      irq_mask;
        logic                  irq;
        logic                  pready;
        logic                  pslverr;
        logic [31:0]           prdata;
    } port_s;

    localparam port_s PORT_RST = '{
        prog_done_n: 1'b1,
        wflag_n:     1'b1,
        rflag_n:     1'b1,
        af_n:        '1,
        wdis:        CTRL_WDIS_RST,
        irq_mask:    IRQ_MASK_RST,
        default:     '0
    };

    port_s s_r;
    port_s s_nxt;

    logic [NUM_QUEUES-1:0][CNT_W-1:0]   q_count;
    logic [NUM_QUEUES-1:0]              af_flag;
    logic [DATA_W-1:0]                  rd_data;
    logic                               wr_go;
    logic                               rd_go;

    // Per-queue almost-full detection
    genvar gi;
    generate
        for (gi = 0; gi < NUM_QUEUES; gi++) begin : g_af
            assign af_flag[gi] =
                (q_count[gi] >= CNT_W'(QUEUE_DEPTH - AF_OFFSET));
        end
    endgenerate

    queue_store u_store (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .wr_en_i   (wr_go),
        .wr_q_i    (s_r.wq),
        .wr_data_i (write_data_i),
        .rd_en_i   (rd_go),
        .rd_q_i    (s_r.rq),
        .rd_data_o (rd_data),
        .count_o   (q_count)
    );

    // Occupancy a queue will hold after this edge
    function automatic logic [CNT_W:0] occ_after(
        input logic [QADDR_W-1:0] q
    );
        logic [CNT_W:0] v;
        v = {1'b0, q_count[q]};
        if (wr_go && s_r.wq == q) begin
            v = v + 1'b1;
        end
        if (rd_go && s_r.rq == q) begin
            v = v - 1'b1;
        end
        return v;
    endfunction

    logic                          done;
    logic                          wr_full;
    logic                          rd_empty;
    logic                          refused;
    logic                          changed;
    logic                          nxt_full;
    logic                          nxt_empty;
    logic                          access;
    logic                          mapped;
    logic [31:0]                   rdval;
    logic [NUM_QUEUES/AF_BUS_W-1:0][AF_BUS_W-1:0] af_words;

    assign af_words = af_flag;

    always_comb begin
        s_nxt     = s_r;
        done      = !s_r.prog_done_n;
        wr_full   = (q_count[s_r.wq] == CNT_W'(QUEUE_DEPTH));
        rd_empty  = (q_count[s_r.rq] == '0);
        // Writes into the current queue, strobe cycles included
        wr_go     = done && !write_en_n_i && !wr_full && !s_r.wdis;
        refused   = done && !write_en_n_i && wr_full;
        rd_go     = done && !read_en_n_i && !rd_empty;
        changed   = 1'b0;
        access    = psel_i && penable_i;
        mapped    = 1'b0;
        rdval     = '0;

        // Modes are caught once, on the first cycle after reset
        if (!s_r.mode_seen) begin
            s_nxt.mode_pkt  = packet_mode_select_i;
            s_nxt.mode_ft   = fall_through_select_i;
            s_nxt.mode_seen = 1'b1;
        end

        // Internal setup delay; port activity is ignored until done
        if (s_r.prog_done_n) begin
            if (s_r.prog_cnt == PROG_CNT_W'(PROG_CYCLES - 1)) begin
                s_nxt.prog_done_n = 1'b0;
            end else begin
                s_nxt.prog_cnt = s_r.prog_cnt + 1'b1;
            end
        end

        // Pending change counts out the cycles still owned by old queue
        if (s_r.chg_busy) begin
            if (s_r.chg_cnt == '0) begin
                s_nxt.wq       = s_r.pend_q;
                s_nxt.chg_busy = 1'b0;
                changed        = 1'b1;
            end else begin
                s_nxt.chg_cnt = s_r.chg_cnt - 1'b1;
            end
        end

        // Queue select; a fresh strobe restarts any change in flight not completing on this edge
        if (done && write_addr_strobe_i && !flag_status_strobe_i &&
            write_addr_bus_i[DEVSEL_BIT] == device_id_i) begin
            s_nxt.pend_q   = write_addr_bus_i[QADDR_W-1:0];
            s_nxt.chg_cnt  = CHG_LOAD;
            s_nxt.chg_busy = 1'b1;
        end

        // Status word select for the almost-full bus
        if (done && flag_status_strobe_i && !write_addr_strobe_i &&
            write_addr_bus_i[DEVSEL_BIT] == device_id_i) begin
            s_nxt.af_word = write_addr_bus_i[STAT_WORD_W-1:0];
        end
        s_nxt.af_n = ~af_words[s_nxt.af_word];

        // Read queue select takes effect at the next edge
        if (done && read_addr_strobe_i &&
            read_addr_bus_i[DEVSEL_BIT] == device_id_i) begin
            s_nxt.rq = read_addr_bus_i[QADDR_W-1:0];
        end

        // Flags reflect the queues selected after this edge
        nxt_full  = (occ_after(s_nxt.wq) == (CNT_W+1)'(QUEUE_DEPTH));
        nxt_empty = (occ_after(s_nxt.rq) == '0);
        if (s_r.mode_ft) begin
            s_nxt.wflag_n = nxt_full;
            s_nxt.rflag_n = nxt_empty;
        end else begin
            s_nxt.wflag_n = !nxt_full;
            s_nxt.rflag_n = !nxt_empty;
        end

        // Register read mux
        case (paddr_i)
            REG_CTRL: begin
                mapped = 1'b1;
                rdval[CTRL_WDIS_BIT] = s_r.wdis;
            end
            REG_STATUS: begin
                mapped = 1'b1;
                rdval[ST_PKT_BIT]  = s_r.mode_pkt;
                rdval[ST_FT_BIT]   = s_r.mode_ft;
                rdval[ST_DONE_BIT] = done;
                rdval[ST_BUSY_BIT] = s_r.chg_busy;
                rdval[ST_WQ_LSB +: QADDR_W] = s_r.wq;
                rdval[ST_RQ_LSB +: QADDR_W] = s_r.rq;
            end
            REG_IRQ_STAT: begin
                mapped = 1'b1;
                rdval[IRQ_W-1:0] = s_r.irq_stat;
            end
            REG_IRQ_MASK: begin
                mapped = 1'b1;
                rdval[IRQ_W-1:0] = s_r.irq_mask;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase

        // One wait state: pready rises in the second access cycle
        if (access && !s_r.pready) begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = !mapped;
            s_nxt.prdata  = pwrite_i ? 32'h0000_0000 : rdval;
        end else begin
            s_nxt.pready  = 1'b0;
            s_nxt.pslverr = 1'b0;
        end

        // Writes commit on the edge that completes the transfer
        if (access && s_r.pready && pwrite_i && mapped) begin
            case (paddr_i)
                REG_CTRL: begin
                    s_nxt.wdis = pwdata_i[CTRL_WDIS_BIT];
                end
                REG_IRQ_STAT: begin
                    s_nxt.irq_stat = s_r.irq_stat & ~pwdata_i[IRQ_W-1:0];
                end
                REG_IRQ_MASK: begin
                    s_nxt.irq_mask = pwdata_i[IRQ_W-1:0];
                end
                default: begin
                    s_nxt.wdis = s_r.wdis;
                end
            endcase
        end

        // Hardware set wins over a same-cycle clear
        if (refused) begin
            s_nxt.irq_stat[IRQ_REFUSED_BIT] = 1'b1;
        end
        if (changed) begin
            s_nxt.irq_stat[IRQ_CHANGED_BIT] = 1'b1;
        end
        s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_r <= PORT_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign write_flag_n_o   = s_r.wflag_n;
    assign almost_full_n_o  = s_r.af_n;
    assign read_data_o      = rd_data;
    assign read_flag_n_o    = s_r.rflag_n;
    assign program_done_n_o = s_r.prog_done_n;
    assign prdata_o         = s_r.prdata;
    assign pready_o         = s_r.pready;
    assign pslverr_o        = s_r.pslverr;
    assign irq_o            = s_r.irq;

endmodule

`default_nettype wire

// file: testbench/mq_write_props.sv
`timescale 1ns/100ps
`default_nettype none

module mq_write_props (
    input wire logic       sys_clk_i,
    input wire logic       rst_i,
    input wire logic       psel_i,
    input wire logic       penable_i,
    input wire logic       pwrite_i,
    input wire logic       pready_o,
    input wire logic       pslverr_o,
    input wire logic       irq_o,
    input wire logic       program_done_n_o,
    input wire logic       write_flag_n_o,
    input wire logic [7:0] almost_full_n_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_reset_idle: assert property ($fell(rst_i) |-> program_done_n_o
        && write_flag_n_o
        && almost_full_n_o == 8'hff && !irq_o && !pready_o)
        else $error("outputs not idle after reset");
    a_prog_done: assert property (
        $fell(rst_i) |-> program_done_n_o [*6] ##[1:3] !program_done_n_o)
        else $error("programming done at wrong time");
    a_done_stays: assert property (
        !program_done_n_o |=> !program_done_n_o)
        else $error("programming done returned high");
    a_apb_answer: assert property (
        psel_i && penable_i && !$past(penable_i) |=> pready_o)
        else $error("pready not in second access cycle");
    a_pready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready held longer than one cycle");
    a_pready_access: assert property (pready_o |-> psel_i && penable_i)
        else $error("pready outside an access");
    a_slverr_pair: assert property (pslverr_o |-> pready_o)
        else $error("pslverr without pready");
    a_irq_fall: assert property ($fell(irq_o) |-> $past(rst_i)
        || ($past(psel_i) && $past(pwrite_i))
        || ($past(psel_i, 2) && $past(pwrite_i, 2)))
        else $error("irq dropped without a register write");

    c_irq: cover property ($rose(irq_o));
    c_err: cover property (pslverr_o);
    c_flag: cover property ($fell(write_flag_n_o));
endmodule

bind multi_queue_write_port_select mq_write_props u_props (
    .sys_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .pready_o,
    .pslverr_o, .irq_o, .program_done_n_o, .write_flag_n_o,
    .almost_full_n_o
);

`default_nettype wire

// file: testbench/mq_producer.sv
`timescale 1ns/100ps
`default_nettype none

module mq_producer
    import mq_pkg::*;
(
    // Clock and status
    input  wire logic              clk_i,
    input  wire logic              program_done_n_i,
    // Write port
    output logic [DATA_W-1:0]      write_data_o,
    output logic                   write_en_n_o,
    output logic [ADDR_W-1:0]      write_addr_bus_o,
    output logic                   write_addr_strobe_o,
    output logic                   flag_status_strobe_o
);
    initial begin
        write_data_o = '0;
        write_en_n_o = 1'b1;
        write_addr_bus_o = '0;
        write_addr_strobe_o = 1'b0;
        flag_status_strobe_o = 1'b0;
    end

    // Nothing is driven on the port until programming is over
    task automatic wait_done(output logic ok);
        int n;
        for (n = 0; n < 40 && program_done_n_i !== 1'b0; n++)
            @(posedge clk_i);
        ok = (program_done_n_i === 1'b0);
    endtask

    // One cycle; data moves every cycle so a stale word shows up
    task automatic drive(input logic s, input logic f,
                         input logic [7:0] a, input logic wn);
        @(posedge clk_i);
        write_addr_strobe_o <= s;
        flag_status_strobe_o <= f;
        write_addr_bus_o <= a;
        write_en_n_o <= wn;
        write_data_o <= write_data_o + 1'b1;
    endtask
endmodule

`default_nettype wire

// file: testbench/tb_multi_queue_write_port_select.sv
`timescale 1ns/100ps
`default_nettype none

module tb_multi_queue_write_port_select
    import mq_pkg::*;
;
    logic              sys_clk = 1'b0;
    logic              rst, pkt, ft, psel, penable, pwrite;
    logic              pready, pslverr, irq, wflag_n, done_n, e, ok;
    logic              wen_n, wstb, fstb;
    logic [7:0]        paddr, af_n;
    logic [31:0]       pwdata, prdata, r;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata, first_w;
    logic [ADDR_W-1:0] raddr;
    logic              rflag_n, rstb, ren_n;
    int                errors = 0;
    int                checks_done = 0;

    always #20 sys_clk = ~sys_clk;

    multi_queue_write_port_select u_multi_queue_write_port_select (
        .sys_clk_i(sys_clk), .rst_i(rst), .packet_mode_select_i(pkt),
        .fall_through_select_i(ft), .device_id_i(1'b0),
        .write_data_i(wdata), .write_en_n_i(wen_n),
        .write_addr_bus_i(waddr), .write_addr_strobe_i(wstb),
        .flag_status_strobe_i(fstb), .write_flag_n_o(wflag_n),
        .almost_full_n_o(af_n), .read_addr_bus_i(raddr),
        .read_addr_strobe_i(rstb), .read_en_n_i(ren_n),
        .read_data_o(rdata), .read_flag_n_o(rflag_n),
        .program_done_n_o(done_n), .paddr_i(paddr),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .irq_o(irq)
    );

    mq_producer u_producer (
        .clk_i(sys_clk), .program_done_n_i(done_n), .write_data_o(wdata),
        .write_en_n_o(wen_n), .write_addr_bus_o(waddr),
        .write_addr_strobe_o(wstb), .flag_status_strobe_o(fstb)
    );

    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string n, input logic [35:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", n, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            errors++;
            close_out();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_irq(input logic v);
        int n;
        for (n = 0; n < 10 && irq !== v; n++)
            @(posedge sys_clk);
        chk("irq", irq, v);
        if (irq !== v)
            close_out();
    endtask

    task automatic do_reset(input logic p, input logic f);
        @(posedge sys_clk);
        rst <= 1'b1;
        pkt <= p;
        ft <= f;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        u_producer.wait_done(ok);
        chk("prog_done", ok, 1'b1);
        if (!ok)
            close_out();
    endtask

    task automatic sc_change();
        do_reset(1'b0, 1'b0);
        u_producer.drive(1'b1, 1'b0, 8'h01, 1'b1);
        for (int i = 0; i < 8; i++)
            u_producer.drive(1'b0, 1'b0, 8'h01, i < 3 || i > 6);
        #1;
        chk("full", wflag_n, 1'b0);
        // Old queue is full, so the flag reveals the switch edge
        for (int i = 0; i < 8; i++) begin
            u_producer.drive(i == 0, 1'b0, 8'h02, i == 7);
            #1;
            if (i == 3)
                first_w = wdata;
            chk("chg_flag", wflag_n, i > 2 && i < 7);
        end
        // A select for another device must leave the full queue in place
        u_producer.drive(1'b1, 1'b0, 8'h85, 1'b1);
        repeat (4)
            u_producer.drive(1'b0, 1'b0, 8'h85, 1'b1);
        #1;
        chk("foreign_sel", wflag_n, 1'b0);
        u_producer.drive(1'b0, 1'b1, 8'h01, 1'b1);
        u_producer.drive(1'b0, 1'b0, 8'h00, 1'b1);
        #1;
        chk("af_word1", af_n, 8'hff);
        u_producer.drive(1'b0, 1'b1, 8'h00, 1'b1);
        u_producer.drive(1'b0, 1'b0, 8'h00, 1'b1);
        #1;
        chk("af_word0", af_n, 8'hf9);
        // Read back the first word the new queue took
        @(posedge sys_clk);
        rstb <= 1'b1;
        raddr <= 8'h02;
        @(posedge sys_clk);
        rstb <= 1'b0;
        ren_n <= 1'b0;
        @(posedge sys_clk);
        ren_n <= 1'b1;
        #1;
        chk("rd_flag", rflag_n, 1'b1);
        chk("rd_data", rdata, first_w);
    endtask

    task automatic sc_regs();
        apb(1'b0, REG_IRQ_STAT, 32'h0);
        chk("irq_stat", r[IRQ_W-1:0], 2'h3);
        chk("irq_masked", irq, 1'b0);
        apb(1'b0, REG_IRQ_MASK, 32'h0);
        chk("mask_rst", r[IRQ_W-1:0], IRQ_MASK_RST);
        apb(1'b1, REG_IRQ_MASK, 32'h1);
        wait_irq(1'b1);
        apb(1'b1, REG_IRQ_STAT, 32'h3);
        wait_irq(1'b0);
        apb(1'b0, REG_IRQ_STAT, 32'h0);
        chk("irq_clr", r[IRQ_W-1:0], 2'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", e, 1'b1);
        chk("unmapped_rd", r, 32'h0);
        // Queue holds three words; a blocked write keeps it not full
        apb(1'b1, REG_CTRL, 32'h1);
        u_producer.drive(1'b0, 1'b0, 8'h00, 1'b0);
        u_producer.drive(1'b0, 1'b0, 8'h00, 1'b1);
        #1;
        chk("wdis_block", wflag_n, 1'b1);
        apb(1'b1, REG_CTRL, 32'h0);
        u_producer.drive(1'b0, 1'b0, 8'h00, 1'b0);
        u_producer.drive(1'b0, 1'b0, 8'h00, 1'b1);
        #1;
        chk("wdis_clear", wflag_n, 1'b0);
    endtask

    task automatic sc_ready();
        do_reset(1'b0, 1'b1);
        u_producer.drive(1'b1, 1'b0, 8'h03, 1'b1);
        for (int i = 0; i < 9; i++) begin
            u_producer.drive(1'b0, 1'b0, 8'h03, i < 3 || i > 6);
            #1;
            if (i > 2)
                chk("ready", wflag_n, i > 6);
        end
    endtask

    initial begin
        rst = 1'b1;
        pkt = 1'b0;
        ft = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        rstb = 1'b0;
        ren_n = 1'b1;
        raddr = '0;
        for (int m = 0; m < 4; m++) begin
            do_reset(m[1], m[0]);
            apb(1'b0, REG_STATUS, 32'h0);
            chk("mode", r[1:0], {m[0], m[1]});
            chk("wflag_idle", wflag_n, !m[0]);
            chk("rflag_idle", rflag_n, m[0]);
        end
        sc_change();
        sc_regs();
        sc_ready();
        close_out();
    end
endmodule

`default_nettype wire
